// [core/eicb_top.sv]
// External interrupt control bank: flags, enables, priorities, bus interrupt and requests to the core
`timescale 1ns/100ps
module eicb_top #(
  parameter bit RISING = 1'b1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // External interrupt pins
  input wire logic ext_irq_input_a,
  input wire logic ext_irq_input_b,
  input wire logic ext_irq_input_c,
  // Priority of input c, held by neighbouring logic
  input wire logic ext_irq_c_priority,
  // Requests toward the core
  output logic [2:0] ext_irq_req,
  output logic irq_req_high,
  output logic irq_req_low,
  // Bus interrupt
  output logic irq
);
  localparam int N = eicb_pkg::N_EXT;

  eicb_evt_if #(.N(N)) evt_if ();
  eicb_reg_if reg_if ();

  logic [eicb_pkg::PRIO_W-1:0] prio_q;
  logic [N-1:0] en_q;
  logic [N-1:0] flag_q;
  logic [N-1:0] flag_d;
  logic [N-1:0] stat_q;
  logic [N-1:0] stat_d;
  logic [N-1:0] mask_q;
  logic [N-1:0] req_q;
  logic req_high_q;
  logic req_low_q;
  logic irq_q;
  logic [N-1:0] evt;
  logic [N-1:0] pend;
  logic [N-1:0] prio_vec;
  logic [eicb_pkg::CTRL_W-1:0] ctrl_word;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;

  function automatic logic hit(input logic [eicb_pkg::ADDR_W-1:0] a, input logic [eicb_pkg::ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  eicb_edge #(
    .N(N),
    .RISING(RISING)
  ) u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .pins({ext_irq_input_c, ext_irq_input_b, ext_irq_input_a}),
    .evt(evt_if.src)
  );

  eicb_ahb u_ahb (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .regs(reg_if.bus)
  );

  assign evt = evt_if.pulse;
  assign wr_ctrl = reg_if.wr_en & hit(reg_if.addr, eicb_pkg::OFF_CTRL);
  assign wr_stat = reg_if.wr_en & hit(reg_if.addr, eicb_pkg::OFF_STAT);
  assign wr_mask = reg_if.wr_en & hit(reg_if.addr, eicb_pkg::OFF_MASK);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prio_q <= eicb_pkg::PRIO_RST;
    end else if (wr_ctrl) begin
      prio_q <= reg_if.wdata[eicb_pkg::PRIO_LSB +: eicb_pkg::PRIO_W];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= eicb_pkg::EN_RST;
    end else if (wr_ctrl) begin
      en_q <= reg_if.wdata[eicb_pkg::EN_LSB +: N];
    end
  end

  always_comb begin
    flag_d = (wr_ctrl ? reg_if.wdata[eicb_pkg::FLAG_LSB +: N] : flag_q) | evt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= eicb_pkg::FLAG_RST;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Bus status: write one to clear, a new event wins
  always_comb begin
    stat_d = (stat_q & ~(wr_stat ? reg_if.wdata[N-1:0] : eicb_pkg::STAT_RST)) | evt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= eicb_pkg::STAT_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= eicb_pkg::MASK_RST;
    end else if (wr_mask) begin
      mask_q <= reg_if.wdata[N-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign pend = flag_q & en_q;
  assign prio_vec = {ext_irq_c_priority, prio_q};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
      req_high_q <= 1'b0;
      req_low_q <= 1'b0;
    end else begin
      req_q <= pend;
      req_high_q <= |(pend & prio_vec);
      req_low_q <= |(pend & ~prio_vec);
    end
  end

  assign ext_irq_req = req_q;
  assign irq_req_high = req_high_q;
  assign irq_req_low = req_low_q;
  assign irq = irq_q;

  assign ctrl_word = {prio_q, en_q, flag_q};

  always_comb begin
    reg_if.rdata = eicb_pkg::WORD_ZERO;
    case (reg_if.addr)
      eicb_pkg::OFF_CTRL: reg_if.rdata[eicb_pkg::CTRL_W-1:0] = ctrl_word;
      eicb_pkg::OFF_STAT: reg_if.rdata[N-1:0] = stat_q;
      eicb_pkg::OFF_MASK: reg_if.rdata[N-1:0] = mask_q;
      eicb_pkg::OFF_PEND: begin
        reg_if.rdata[N-1:0] = pend;
        reg_if.rdata[eicb_pkg::PEND_HI_BIT] = |(pend & prio_vec);
        reg_if.rdata[eicb_pkg::PEND_LO_BIT] = |(pend & ~prio_vec);
      end
      default: reg_if.rdata = eicb_pkg::WORD_ZERO;
    endcase
  end

  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic rd_ctrl;
  logic rd_accept;
  logic wr_accept;
  logic rd_pend;
  logic rd_stat;
  assign rd_ctrl = reg_if.rd_en & hit(reg_if.addr, eicb_pkg::OFF_CTRL);
  assign rd_accept = hsel & hready & htrans[eicb_pkg::HTRANS_ACT_BIT] & ~hwrite;
  assign wr_accept = hsel & hready & htrans[eicb_pkg::HTRANS_ACT_BIT] & hwrite;
  assign rd_pend = reg_if.rd_en & hit(reg_if.addr, eicb_pkg::OFF_PEND);
  assign rd_stat = reg_if.rd_en & hit(reg_if.addr, eicb_pkg::OFF_STAT);

  AST_PRIO_AFTER_RESET: assert property ($rose(hresetn) |-> prio_q == eicb_pkg::PRIO_RST)
    else $error("priority bits not high after reset");

  AST_PRIO_WRITE: assert property (wr_ctrl |=> prio_q == $past(reg_if.wdata[eicb_pkg::PRIO_LSB +: eicb_pkg::PRIO_W]))
    else $error("priority bits did not take written value");

  AST_FLAG_SET_BY_EVENT: assert property (|evt |=> (flag_q & $past(evt)) == $past(evt))
    else $error("event did not set its flag");

  AST_FLAG_SET_WHILE_DISABLED: assert property ((|(evt & ~en_q)) |=> (flag_q & $past(evt & ~en_q)) == $past(evt & ~en_q))
    else $error("disabled input event lost its flag");

  AST_FLAG_STICKY: assert property (!wr_ctrl |=> ($past(flag_q) & ~flag_q) == 3'h0)
    else $error("flag dropped without a software write");

  AST_FLAG_CLEAR: assert property ((wr_ctrl && evt == 3'h0) |=> flag_q == $past(reg_if.wdata[eicb_pkg::FLAG_LSB +: N]))
    else $error("flag write of zero did not clear");

  AST_FLAG_READBACK: assert property (rd_ctrl |=> hrdata[eicb_pkg::CTRL_W-1:0] == $past(ctrl_word))
    else $error("control read does not show flags");

  AST_REQ_GATED: assert property (##1 ext_irq_req == $past(flag_q & en_q))
    else $error("request not flag and enable");

  AST_REQ_NEEDS_ENABLE: assert property ((en_q == 3'h0) [*2] |-> ext_irq_req == 3'h0)
    else $error("request with all inputs disabled");

  AST_READ_WAIT: assert property (rd_accept |=> !hreadyout ##1 hreadyout)
    else $error("read wait state missing");

  AST_IRQ_LEVEL: assert property ((stat_q & mask_q) != 3'h0 |=> irq)
    else $error("unmasked status did not raise irq");

  // Reset values and control register fields
  AST_EN_AFTER_RESET: assert property ($rose(hresetn) |-> en_q == eicb_pkg::EN_RST)
    else $error("enable bits not clear after reset");

  AST_FLAG_AFTER_RESET: assert property ($rose(hresetn) |-> flag_q == eicb_pkg::FLAG_RST)
    else $error("flags not clear after reset");

  AST_IRQ_AFTER_RESET: assert property ($rose(hresetn) |-> !irq && ext_irq_req == '0)
    else $error("request or irq active after reset");

  AST_EN_WRITE: assert property (wr_ctrl |=> en_q == $past(reg_if.wdata[eicb_pkg::EN_LSB +: N]))
    else $error("enable bits did not take written value");

  AST_PRIO_HOLD: assert property (!wr_ctrl |=> $stable(prio_q))
    else $error("priority bits changed without a write");

  AST_EN_HOLD: assert property (!wr_ctrl |=> $stable(en_q))
    else $error("enable bits changed without a write");

  AST_FLAG_NO_SPURIOUS: assert property ((!wr_ctrl && evt == '0) |=> $stable(flag_q))
    else $error("flag changed with no event and no write");

  AST_EVT_ONE_CYCLE: assert property (|evt |=> (evt & $past(evt)) == '0)
    else $error("event pulse longer than one cycle");

  AST_REQ_HIGH: assert property (##1 irq_req_high == $past(|(flag_q & en_q & prio_vec)))
    else $error("high priority request wrong");

  AST_REQ_LOW: assert property (##1 irq_req_low == $past(|(flag_q & en_q & ~prio_vec)))
    else $error("low priority request wrong");

  AST_PEND_READBACK: assert property (rd_pend |=> hrdata[N-1:0] == $past(flag_q & en_q))
    else $error("pending read does not show flag and enable");

  AST_RDATA_UPPER_ZERO: assert property (rd_ctrl |=> hrdata[31:eicb_pkg::CTRL_W] == '0)
    else $error("control read has bits above the fields");

  // Status, mask and bus side
  AST_STAT_READBACK: assert property (rd_stat |=> hrdata[N-1:0] == $past(stat_q))
    else $error("status read wrong");

  AST_STAT_SET: assert property (|evt |=> (stat_q & $past(evt)) == $past(evt))
    else $error("event did not set its status bit");

  AST_STAT_CLEAR: assert property ((wr_stat && evt == '0) |=> (stat_q & $past(reg_if.wdata[N-1:0])) == '0)
    else $error("status write of one did not clear");

  AST_STAT_NO_SPURIOUS: assert property (evt == '0 |=> (stat_q & ~$past(stat_q)) == '0)
    else $error("status bit set without an event");

  AST_MASK_WRITE: assert property (wr_mask |=> mask_q == $past(reg_if.wdata[N-1:0]))
    else $error("mask did not take written value");

  AST_MASK_HOLD: assert property (!wr_mask |=> $stable(mask_q))
    else $error("mask changed without a write");

  AST_IRQ_QUIET: assert property ((stat_q & mask_q) == '0 |=> !irq)
    else $error("irq high with no unmasked status");

  AST_RESP_OKAY: assert property (hresp == eicb_pkg::HRESP_OKAY)
    else $error("response not okay");

  AST_WRITE_NO_WAIT: assert property (wr_accept |=> hreadyout)
    else $error("write data phase stretched");

  AST_HRDATA_HOLD: assert property (!reg_if.rd_en |=> $stable(hrdata))
    else $error("read data changed outside a read wait");

  COV_EVENT_DISABLED: cover property (evt[0] && !en_q[0] ##1 flag_q[0]);
  COV_CLEAR_THEN_ENABLE: cover property (wr_ctrl && reg_if.wdata[0] == 1'b0 ##[1:20] wr_ctrl && reg_if.wdata[3]);
  COV_HIGH_REQ: cover property (irq_req_high);
  COV_FLAG_POLL: cover property (rd_ctrl && flag_q != '0);
  COV_SET_CLEAR_CLASH: cover property (wr_ctrl && evt[1] && !reg_if.wdata[1]);
endmodule

// [core/eicb_pkg.sv]
// Constants of the external interrupt control bank: offsets, field positions and reset values
// Function
// - Two writable priority bits, bit 7 for input b and bit 6 for input a, one meaning high, both one after reset.
// - Each input's flag in bits 2 to 0 is set by its event or by a software write of one, stays set until software writes it to zero, and reads zero otherwise.
// - A flag is set by its event whatever the state of its enable bit.
// - The flags can be read at any time, also while disabled, so that software can poll for events.
package eicb_pkg;
  // Register layout
  localparam int N_EXT = 3;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_PEND = 8'h0c;
  localparam int FLAG_LSB = 0;
  localparam int EN_LSB = 3;
  localparam int PRIO_LSB = 6;
  localparam int PRIO_W = 2;
  localparam int CTRL_W = 8;
  localparam int PEND_HI_BIT = 3;
  localparam int PEND_LO_BIT = 4;
  // Reset values
  localparam logic [1:0] PRIO_RST = 2'h3;
  localparam logic [2:0] EN_RST = 3'h0;
  localparam logic [2:0] FLAG_RST = 3'h0;
  localparam logic [2:0] STAT_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // Bus encodings
  localparam int HTRANS_ACT_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;
  // Bus slave states
  typedef enum logic [3:0] {
    EICB_S_IDLE = 4'h1,
    EICB_S_WR = 4'h2,
    EICB_S_RDW = 4'h4,
    EICB_S_RDD = 4'h8
  } eicb_bus_state_t;
endpackage

// [core/eicb_if.sv]
// Carriers between the bank's own modules: event pulses and register access
`timescale 1ns/100ps
interface eicb_evt_if #(
  parameter int N = eicb_pkg::N_EXT
);
  logic [N-1:0] pulse;
  modport src (output pulse);
  modport dst (input pulse);
endinterface

interface eicb_reg_if;
  logic wr_en;
  logic rd_en;
  logic [eicb_pkg::ADDR_W-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport bus (output wr_en, output rd_en, output addr, output wdata, input rdata);
  modport core (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface

// [core/eicb_edge.sv]
// Pin synchronisers and edge detectors of the external interrupt inputs
`timescale 1ns/100ps
module eicb_edge #(
  parameter int N = eicb_pkg::N_EXT,
  parameter bit RISING = 1'b1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pins and event pulses
  input wire logic [N-1:0] pins,
  eicb_evt_if.src evt
);
  localparam logic IDLE_LEVEL = RISING ? 1'b0 : 1'b1;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_in
      logic meta_q;
      logic sync_q;
      logic prev_q;
      // First stage feeds only the second
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta_q <= IDLE_LEVEL;
          sync_q <= IDLE_LEVEL;
          prev_q <= IDLE_LEVEL;
        end else begin
          meta_q <= pins[i];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end
      assign evt.pulse[i] = RISING ? (sync_q & ~prev_q) : (~sync_q & prev_q);
    end
  endgenerate
endmodule

// [core/eicb_ahb.sv]
// AHB-Lite slave front end: zero-wait writes, reads with one wait state
`timescale 1ns/100ps
module eicb_ahb (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Register side
  eicb_reg_if.bus regs
);
  eicb_pkg::eicb_bus_state_t state_q;
  eicb_pkg::eicb_bus_state_t state_d;
  logic [eicb_pkg::ADDR_W-1:0] addr_q;
  logic [31:0] hrdata_q;
  logic accept;

  assign accept = hsel & hready & htrans[eicb_pkg::HTRANS_ACT_BIT];

  always_comb begin
    state_d = eicb_pkg::EICB_S_IDLE;
    case (state_q)
      eicb_pkg::EICB_S_RDW: state_d = eicb_pkg::EICB_S_RDD;
      eicb_pkg::EICB_S_IDLE, eicb_pkg::EICB_S_WR, eicb_pkg::EICB_S_RDD: begin
        if (accept) begin
          state_d = hwrite ? eicb_pkg::EICB_S_WR : eicb_pkg::EICB_S_RDW;
        end
      end
      default: state_d = eicb_pkg::EICB_S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= eicb_pkg::EICB_S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= '0;
    end else if (accept) begin
      addr_q <= haddr[eicb_pkg::ADDR_W-1:0];
    end
  end

  // Read data sampled in the wait state, after any earlier write has landed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= eicb_pkg::WORD_ZERO;
    end else if (state_q == eicb_pkg::EICB_S_RDW) begin
      hrdata_q <= regs.rdata;
    end
  end

  assign regs.wr_en = (state_q == eicb_pkg::EICB_S_WR);
  assign regs.rd_en = (state_q == eicb_pkg::EICB_S_RDW);
  assign regs.addr = addr_q;
  assign regs.wdata = hwdata;
  assign hreadyout = (state_q != eicb_pkg::EICB_S_RDW);
  assign hresp = eicb_pkg::HRESP_OKAY;
  assign hrdata = hrdata_q;
endmodule

// [sim/eicb_pin_model.sv]
// Behavioural driver of the three external interrupt pins
`timescale 1ns/100ps
module eicb_pin_model (
  // Clock
  input wire logic hclk,
  // Pins, idle low
  output logic ext_irq_input_a,
  output logic ext_irq_input_b,
  output logic ext_irq_input_c
);
  logic [2:0] lvl_q = 3'h0;

  assign ext_irq_input_a = lvl_q[0];
  assign ext_irq_input_b = lvl_q[1];
  assign ext_irq_input_c = lvl_q[2];

  // Raises one pin for len cycles; short and long pulses both clear the synchroniser
  task automatic pulse(input int idx, input int len);
    @(posedge hclk);
    lvl_q[idx] <= 1'b1;
    repeat (len) @(posedge hclk);
    lvl_q[idx] <= 1'b0;
  endtask
endmodule

// [sim/tb.sv]
// Self-checking bench of the external interrupt control bank
`timescale 1ns/100ps
module tb;
  logic hclk, hresetn, hsel, hwrite, ext_irq_c_priority;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic hreadyout, hresp, irq, irq_req_high, irq_req_low;
  logic [2:0] ext_irq_req;
  logic pin_a, pin_b, pin_c;
  int bad_count = 0;
  int checked = 0;
  localparam logic [7:0] OFF_NONE = 8'h10;
  localparam logic [31:0] CTRL_RST = {24'h0, eicb_pkg::PRIO_RST, eicb_pkg::EN_RST, eicb_pkg::FLAG_RST};
  localparam logic [31:0] EN_ALL = 32'h38;

  eicb_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ext_irq_input_a(pin_a), .ext_irq_input_b(pin_b), .ext_irq_input_c(pin_c),
    .ext_irq_c_priority(ext_irq_c_priority), .ext_irq_req(ext_irq_req), .irq_req_high(irq_req_high),
    .irq_req_low(irq_req_low), .irq(irq));

  eicb_pin_model pins (.hclk(hclk), .ext_irq_input_a(pin_a), .ext_irq_input_b(pin_b), .ext_irq_input_c(pin_c));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One single AHB-Lite transfer; waits for hready in both phases
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask

  // Pin event, then time for sync, flag and registered requests
  task automatic fire(input int idx, input int len);
    pins.pulse(idx, len);
    repeat (8) @(posedge hclk);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge hclk);
    bad_count++;
    $display("unexpected at %0t ns: watchdog expired", $time);
    test_done;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    ext_irq_c_priority = 1'b1;
    repeat (10) @(posedge hclk);
    chk({26'h0, ext_irq_req, irq, irq_req_high, irq_req_low}, 32'h0, "outputs in reset");
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(eicb_pkg::OFF_CTRL, CTRL_RST, "control reset");
    rd_chk(eicb_pkg::OFF_MASK, 32'h0, "mask reset");
    rd_chk(OFF_NONE, 32'h0, "unmapped read");
    chk({31'h0, hresp}, 32'h0, "response code");
    $display("test reset done");

    for (int v = 0; v < 4; v++) begin
      wr(eicb_pkg::OFF_CTRL, 32'(v) << eicb_pkg::PRIO_LSB);
      rd_chk(eicb_pkg::OFF_CTRL, 32'(v) << eicb_pkg::PRIO_LSB, "priority bits");
    end
    wr(OFF_NONE, 32'hffff_ffff);
    rd_chk(eicb_pkg::OFF_CTRL, CTRL_RST, "unmapped write ignored");
    $display("test priority done");

    fire(0, 2);
    chk({29'h0, ext_irq_req}, 32'h0, "request while disabled");
    rd_chk(eicb_pkg::OFF_CTRL, CTRL_RST | 32'h1, "flag a polled");
    fire(1, 5);
    fire(2, 2);
    repeat (20) @(posedge hclk);
    rd_chk(eicb_pkg::OFF_CTRL, CTRL_RST | 32'h7, "flags sticky");
    rd_chk(eicb_pkg::OFF_STAT, 32'h7, "status sticky");
    wr(eicb_pkg::OFF_CTRL, CTRL_RST | 32'h5);
    rd_chk(eicb_pkg::OFF_CTRL, CTRL_RST | 32'h5, "flag b cleared");
    $display("test polling done");

    wr(eicb_pkg::OFF_CTRL, CTRL_RST);
    wr(eicb_pkg::OFF_CTRL, CTRL_RST | EN_ALL);
    repeat (3) @(posedge hclk);
    chk({29'h0, ext_irq_req}, 32'h0, "no stale request");
    chk({30'h0, irq_req_high, irq_req_low}, 32'h0, "no stale priority request");
    rd_chk(eicb_pkg::OFF_CTRL, CTRL_RST | EN_ALL, "enables stored");
    fire(2, 2);
    chk({29'h0, ext_irq_req}, 32'h4, "request c");
    chk({30'h0, irq_req_high, irq_req_low}, 32'h2, "c high priority");
    ext_irq_c_priority <= 1'b0;
    repeat (3) @(posedge hclk);
    chk({30'h0, irq_req_high, irq_req_low}, 32'h1, "c low priority");
    rd_chk(eicb_pkg::OFF_PEND, 32'h4 | (32'h1 << eicb_pkg::PEND_LO_BIT), "pending c low");
    fire(0, 2);
    chk({29'h0, ext_irq_req}, 32'h5, "request a and c");
    chk({30'h0, irq_req_high, irq_req_low}, 32'h3, "both priorities");
    wr(eicb_pkg::OFF_CTRL, CTRL_RST | EN_ALL);
    repeat (2) @(posedge hclk);
    chk({29'h0, ext_irq_req}, 32'h0, "requests withdrawn");
    $display("test requests done");

    wr(eicb_pkg::OFF_STAT, 32'h7);
    rd_chk(eicb_pkg::OFF_STAT, 32'h0, "status cleared");
    wr(eicb_pkg::OFF_MASK, 32'h2);
    rd_chk(eicb_pkg::OFF_MASK, 32'h2, "mask stored");
    fire(0, 2);
    chk({31'h0, irq}, 32'h0, "masked event quiet");
    fire(1, 2);
    chk({31'h0, irq}, 32'h1, "unmasked event raises irq");
    wr(eicb_pkg::OFF_STAT, 32'h2);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rd_chk(eicb_pkg::OFF_STAT, 32'h1, "other status kept");
    wr(eicb_pkg::OFF_MASK, 32'h0);
    $display("test interrupt done");
    test_done;
  end
endmodule
